// [src/sync_two_flop.sv]
`timescale 1ns/10ps
module sync_two_flop (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic async_in,
  output logic sync_out
);
  logic stage_one_r;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (rst) begin
      stage_one_r <= 1'b0;
      sync_out <= 1'b0;
    end else if (clock_enable) begin
      stage_one_r <= async_in;
      sync_out <= stage_one_r;
    end
  end
endmodule

// [src/turnaround_timer.sv]
`timescale 1ns/10ps
`include "usb_error_flag_params.svh"
module turnaround_timer
  import usb_error_flag_pkg::*;
#(
  parameter int LIMIT_BITS = `TURNAROUND_LIMIT_BITS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic eop_seen,
  input wire logic bit_tick,
  input wire logic bus_active,
  output logic timeout_pulse
);
  localparam logic [5:0] LIMIT = 6'(LIMIT_BITS);
  turnaround_state_e state_r;
  logic [5:0] count_r;

  // Counts bit times from end of packet until the bus leaves idle
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= TA_IDLE;
      count_r <= 6'h00;
      timeout_pulse <= 1'b0;
    end else if (clock_enable) begin
      timeout_pulse <= 1'b0;
      unique case (state_r)
        TA_IDLE: begin
          if (eop_seen) begin
            state_r <= TA_COUNT;
            count_r <= 6'h00;
          end
        end
        TA_COUNT: begin
          if (bus_active) begin
            state_r <= TA_IDLE;
          end else if (bit_tick) begin
            // More than the limit means the count passes it
            if (count_r == LIMIT) begin
              state_r <= TA_EXPIRED;
              timeout_pulse <= 1'b1;
            end else begin
              count_r <= count_r + 6'h01;
            end
          end
        end
        TA_EXPIRED: begin
          // One report per turnaround; wait for the next packet
          if (eop_seen) begin
            state_r <= TA_COUNT;
            count_r <= 6'h00;
          end else if (bus_active) begin
            state_r <= TA_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// [src/usb_error_flag_params.svh]
`ifndef USB_ERROR_FLAG_PARAMS_SVH
`define USB_ERROR_FLAG_PARAMS_SVH

// Register offsets on the plain register port
`define ERR_FLAGS_OFS 4'h0
`define ERR_ENABLES_OFS 4'h1
`define ERR_CTRL_OFS 4'h2
`define ERR_SUMMARY_OFS 4'h3

// Field positions of the error flag and enable registers
`define BIT_STUFF_POS 7
`define RESERVED_POS 6
`define DMA_FAULT_POS 5
`define TURNAROUND_POS 4
`define PARTIAL_BYTE_POS 3
`define DATA_CHECK_POS 2
`define TOKEN_FRAME_POS 1
`define PID_CHECK_POS 0

// Control register and summary register fields
`define HOST_MODE_POS 3
`define ERROR_SUMMARY_POS 1

// Reset values
`define ERR_FLAGS_RST 8'h00
`define ERR_ENABLES_RST 8'h00
`define ERR_CTRL_RST 8'h00

// Writable bits of the flag and enable registers
`define ERR_WRITABLE_MASK 8'hBF

// Turnaround limit in bit times
`define TURNAROUND_LIMIT_BITS 16

`endif

// [src/usb_error_flag_pkg.sv]
package usb_error_flag_pkg;
  typedef logic [7:0] reg8_t;
  typedef enum logic [1:0] {
    TA_IDLE,
    TA_COUNT,
    TA_EXPIRED
  } turnaround_state_e;
endpackage

// [src/usb_error_flag_unit.sv]
`timescale 1ns/10ps
`include "usb_error_flag_params.svh"
module usb_error_flag_unit
  import usb_error_flag_pkg::*;
#(
  parameter int TURNAROUND_BITS = `TURNAROUND_LIMIT_BITS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic bit_stuff_fault,
  input wire logic dma_grant_late,
  input wire logic buffer_overrun,
  input wire logic eop_seen,
  input wire logic bit_tick,
  input wire logic bus_active,
  input wire logic partial_byte_fault,
  input wire logic data_check_fault,
  input wire logic token_check_fault,
  input wire logic frame_countdown_zero,
  input wire logic transfer_active,
  input wire logic packet_id_check_fault,
  input wire logic rx_byte_valid,
  output logic packet_reject,
  output logic truncate_packet,
  output logic host_mode,
  output logic error_summary,
  output logic irq
);
  reg8_t flags_r;
  reg8_t flags_nxt;
  reg8_t enables_r;
  reg8_t ctrl_r;
  reg8_t set_vec;
  reg8_t clr_vec;
  logic bit_stuff_s;
  logic timeout_pulse;
  logic overrun_q;
  logic combined;
  reg8_t enables_nxt;

  // Write selects decoded once, so every register sees the same address compare
  logic wr_flags_sel;
  logic wr_enables_sel;
  logic wr_ctrl_sel;
  assign wr_flags_sel = reg_write && reg_addr == `ERR_FLAGS_OFS;
  assign wr_enables_sel = reg_write && reg_addr == `ERR_ENABLES_OFS;
  assign wr_ctrl_sel = reg_write && reg_addr == `ERR_CTRL_OFS;

  // The bit stuff detector sits on line sampling logic of its own clock region
  sync_two_flop u_sync_stuff (
    .clock(clock),
    .rst(rst),
    .clock_enable(clock_enable),
    .async_in(bit_stuff_fault),
    .sync_out(bit_stuff_s)
  );

  turnaround_timer #(
    .LIMIT_BITS(TURNAROUND_BITS)
  ) u_turnaround (
    .clock(clock),
    .rst(rst),
    .clock_enable(clock_enable),
    .eop_seen(eop_seen),
    .bit_tick(bit_tick),
    .bus_active(bus_active),
    .timeout_pulse(timeout_pulse)
  );

  // Event vector; bit 1 meaning follows the host mode control
  always_comb begin
    set_vec = 8'h00;
    set_vec[`BIT_STUFF_POS] = bit_stuff_s;
    set_vec[`DMA_FAULT_POS] = dma_grant_late | buffer_overrun;
    set_vec[`TURNAROUND_POS] = timeout_pulse;
    set_vec[`PARTIAL_BYTE_POS] = partial_byte_fault;
    set_vec[`DATA_CHECK_POS] = data_check_fault;
    if (ctrl_r[`HOST_MODE_POS]) begin
      set_vec[`TOKEN_FRAME_POS] = frame_countdown_zero & transfer_active;
    end else begin
      set_vec[`TOKEN_FRAME_POS] = token_check_fault;
    end
    set_vec[`PID_CHECK_POS] = packet_id_check_fault;
  end

  // Write-one-to-clear, reserved bit never cleared or set
  always_comb begin
    clr_vec = 8'h00;
    if (wr_flags_sel) begin
      clr_vec = reg_wdata & `ERR_WRITABLE_MASK;
    end
    // Set applied after clear so a coincident event survives
    flags_nxt = ((flags_r & ~clr_vec) | set_vec) & `ERR_WRITABLE_MASK;
  end

  // Sticky error flags
  always_ff @(posedge clock) begin
    if (rst) begin
      flags_r <= `ERR_FLAGS_RST;
    end else if (clock_enable) begin
      flags_r <= flags_nxt;
    end
  end

  // Next enable value; the summary uses it, so a new enable shows with the same lag as a new flag
  always_comb begin
    enables_nxt = enables_r;
    if (wr_enables_sel) begin
      enables_nxt = reg_wdata & `ERR_WRITABLE_MASK;
    end
  end

  // Enable register; bit 6 masked off on write
  always_ff @(posedge clock) begin
    if (rst) begin
      enables_r <= `ERR_ENABLES_RST;
    end else if (clock_enable) begin
      enables_r <= enables_nxt;
    end
  end

  // Control register: host mode enable at its documented bit
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= `ERR_CTRL_RST;
    end else if (clock_enable && wr_ctrl_sel) begin
      ctrl_r <= reg_wdata & (8'h01 << `HOST_MODE_POS);
    end
  end

  assign combined = |(flags_nxt & enables_nxt);

  // Summary and interrupt registered for glitch-free outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      error_summary <= 1'b0;
      irq <= 1'b0;
      host_mode <= 1'b0;
    end else if (clock_enable) begin
      error_summary <= combined;
      irq <= combined;
      host_mode <= ctrl_r[`HOST_MODE_POS];
    end
  end

  // Reject strobe for stuffing and CRC16 failures
  always_ff @(posedge clock) begin
    if (rst) begin
      packet_reject <= 1'b0;
    end else if (clock_enable) begin
      packet_reject <= bit_stuff_s | data_check_fault;
    end
  end

  // Truncation holds until the overrun packet ends, dropping further bytes
  always_ff @(posedge clock) begin
    if (rst) begin
      overrun_q <= 1'b0;
      truncate_packet <= 1'b0;
    end else if (clock_enable) begin
      if (eop_seen) begin
        overrun_q <= 1'b0;
        truncate_packet <= 1'b0;
      end else if (buffer_overrun) begin
        overrun_q <= 1'b1;
        truncate_packet <= 1'b1;
      end else begin
        truncate_packet <= overrun_q & rx_byte_valid | overrun_q;
      end
    end
  end

  // Read data in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clock_enable) begin
      reg_rdata <= 8'h00;
      if (reg_read) begin
        unique case (reg_addr)
          `ERR_FLAGS_OFS: reg_rdata <= flags_r;
          `ERR_ENABLES_OFS: reg_rdata <= enables_r;
          `ERR_CTRL_OFS: reg_rdata <= ctrl_r;
          `ERR_SUMMARY_OFS: reg_rdata <= 8'(error_summary) << `ERROR_SUMMARY_POS;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Quiet cycles since the last event; saturates so a long spell never wraps to look short
  logic [2:0] since_event;
  always_ff @(posedge clock) begin
    if (rst) begin
      since_event <= 3'h0;
    end else if (clock_enable) begin
      since_event <= (set_vec != 8'h00) ? 3'h0 : (since_event == 3'h7) ? 3'h7 : since_event + 3'h1;
    end
  end

  // Flag setting and clearing checks
  AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (rst) flags_r[6] == 1'b0 && enables_r[6] == 1'b0)
    else $error("reserved bit set");
  AST_STICKY: assert property (@(posedge clock) disable iff (rst)
    clock_enable && flags_r[0] && !(reg_write && reg_addr == `ERR_FLAGS_OFS && reg_wdata[0]) |=> flags_r[0])
    else $error("flag lost without clear");
  AST_W1C: assert property (@(posedge clock) disable iff (rst)
    clock_enable && reg_write && reg_addr == `ERR_FLAGS_OFS && reg_wdata[2] && !data_check_fault |=> !flags_r[2])
    else $error("write one did not clear");
  AST_PID_SET: assert property (@(posedge clock) disable iff (rst)
    clock_enable && packet_id_check_fault |=> flags_r[0])
    else $error("pid fault not flagged");
  AST_STUFF_SET: assert property (@(posedge clock) disable iff (rst)
    clock_enable && bit_stuff_s |=> flags_r[`BIT_STUFF_POS] && packet_reject)
    else $error("stuff fault not flagged");
  AST_HOST_EOF: assert property (@(posedge clock) disable iff (rst)
    clock_enable && ctrl_r[3] && frame_countdown_zero && transfer_active |=> flags_r[1])
    else $error("end of frame not flagged");
  AST_PERIPH_CRC5: assert property (@(posedge clock) disable iff (rst)
    clock_enable && !ctrl_r[3] && token_check_fault |=> flags_r[1])
    else $error("token crc not flagged");
  AST_SUMMARY: assert property (@(posedge clock) disable iff (rst)
    clock_enable |=> error_summary == |(flags_r & enables_r))
    else $error("summary mismatch");
  AST_DMA: assert property (@(posedge clock) disable iff (rst)
    clock_enable && (dma_grant_late || buffer_overrun) |=> flags_r[5])
    else $error("dma fault not flagged");
  AST_RESET_CLEAR: assert property (@(posedge clock) rst |=> flags_r == 8'h00 && enables_r == 8'h00)
    else $error("reset did not clear");

  // Per-source setting checks
  AST_PARTIAL: assert property (@(posedge clock) disable iff (rst)
    clock_enable && partial_byte_fault
    |=> flags_r[`PARTIAL_BYTE_POS])
    else $error("partial byte fault not flagged");
  AST_DATA_CHECK: assert property (@(posedge clock) disable iff (rst)
    clock_enable && data_check_fault
    |=> flags_r[`DATA_CHECK_POS] && packet_reject)
    else $error("data check fault not flagged");
  AST_TIMEOUT: assert property (@(posedge clock) disable iff (rst)
    clock_enable && timeout_pulse
    |=> flags_r[`TURNAROUND_POS])
    else $error("turnaround timeout not flagged");
  AST_OVERRUN: assert property (@(posedge clock) disable iff (rst)
    clock_enable && buffer_overrun && !eop_seen
    |=> flags_r[`DMA_FAULT_POS] && truncate_packet)
    else $error("overrun not flagged");
  AST_HOST_BLOCKS_CRC5: assert property (@(posedge clock) disable iff (rst)
    clock_enable && ctrl_r[`HOST_MODE_POS] && token_check_fault && !flags_r[`TOKEN_FRAME_POS]
    && !(frame_countdown_zero && transfer_active)
    |=> !flags_r[`TOKEN_FRAME_POS])
    else $error("token check flagged in host mode");
  AST_PERIPH_BLOCKS_EOF: assert property (@(posedge clock) disable iff (rst)
    clock_enable && !ctrl_r[`HOST_MODE_POS] && frame_countdown_zero && transfer_active
    && !token_check_fault && !flags_r[`TOKEN_FRAME_POS]
    |=> !flags_r[`TOKEN_FRAME_POS])
    else $error("frame end flagged in peripheral mode");
  AST_NO_SPURIOUS: assert property (@(posedge clock) disable iff (rst)
    clock_enable && set_vec == 8'h00
    |=> (flags_r & ~$past(flags_r)) == 8'h00)
    else $error("flag set without event");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (rst)
    clock_enable && packet_id_check_fault && reg_write && reg_addr == `ERR_FLAGS_OFS && reg_wdata[`PID_CHECK_POS]
    |=> flags_r[`PID_CHECK_POS])
    else $error("clear beat coincident event");
  AST_ZERO_WRITE: assert property (@(posedge clock) disable iff (rst)
    clock_enable && reg_write && reg_addr == `ERR_FLAGS_OFS
    |=> ($past(flags_r) & ~$past(reg_wdata) & ~flags_r) == 8'h00)
    else $error("zero write cleared a flag");

  // Packet handling checks
  AST_TRUNC_HOLD: assert property (@(posedge clock) disable iff (rst)
    clock_enable && truncate_packet && !eop_seen
    |=> truncate_packet)
    else $error("truncation dropped early");
  AST_TRUNC_END: assert property (@(posedge clock) disable iff (rst)
    clock_enable && eop_seen
    |=> !truncate_packet)
    else $error("truncation outlived packet");
  AST_REJECT_ONLY: assert property (@(posedge clock) disable iff (rst)
    clock_enable && !bit_stuff_s && !data_check_fault
    |=> !packet_reject)
    else $error("reject without cause");

  // Register and output checks
  AST_ENABLE_WRITE: assert property (@(posedge clock) disable iff (rst)
    clock_enable && reg_write && reg_addr == `ERR_ENABLES_OFS
    |=> enables_r == ($past(reg_wdata) & `ERR_WRITABLE_MASK))
    else $error("enable write not taken");
  AST_SUMMARY_READ: assert property (@(posedge clock) disable iff (rst)
    clock_enable && reg_read && reg_addr == `ERR_SUMMARY_OFS
    |=> reg_rdata[`ERROR_SUMMARY_POS] == $past(error_summary) && (reg_rdata & ~(8'h01 << `ERROR_SUMMARY_POS)) == 8'h00)
    else $error("summary read wrong");
  AST_READ_IDLE: assert property (@(posedge clock) disable iff (rst)
    clock_enable && !reg_read
    |=> reg_rdata == 8'h00)
    else $error("read data without read");
  AST_CTRL_ONLY_HOST: assert property (@(posedge clock) disable iff (rst)
    (ctrl_r & ~(8'h01 << `HOST_MODE_POS)) == 8'h00)
    else $error("control holds more than host mode");
  AST_HOST_COPY: assert property (@(posedge clock) disable iff (rst)
    clock_enable
    |=> host_mode == $past(ctrl_r[`HOST_MODE_POS]))
    else $error("host mode output stale");
  AST_IRQ_FOLLOWS: assert property (@(posedge clock) disable iff (rst)
    irq == error_summary)
    else $error("interrupt differs from summary");
  AST_FREEZE: assert property (@(posedge clock) disable iff (rst)
    !clock_enable
    |=> $stable(flags_r) && $stable(enables_r) && $stable(ctrl_r))
    else $error("state moved while frozen");
  AST_RESET_OUTPUTS: assert property (@(posedge clock)
    rst
    |=> !irq && !error_summary && !packet_reject && !truncate_packet && !host_mode && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");

  // Main scenarios
  COV_IRQ: cover property (@(posedge clock) disable iff (rst) $rose(irq));
  COV_TRUNCATE: cover property (@(posedge clock) disable iff (rst) $fell(truncate_packet));
  COV_TIMEOUT: cover property (@(posedge clock) disable iff (rst) timeout_pulse);
  COV_SET_CLEAR: cover property (@(posedge clock) disable iff (rst)
    reg_write && reg_addr == `ERR_FLAGS_OFS && reg_wdata[0] && packet_id_check_fault);
  COV_HOST: cover property (@(posedge clock) disable iff (rst) ctrl_r[3] && since_event == 3'h7);
endmodule

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
  typedef struct {logic [3:0] kind; logic [7:0] ctrl; logic [7:0] flags;} row_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic clock_enable = 1'b1;
  logic fire = 1'b0;
  logic [3:0] kind = 4'h0;
  logic bsf, dgl, bov, eop, btk, bac, pbf, dcf, tcf, fcz, tra, pid, rbv;
  logic packet_reject, truncate_packet, host_mode, error_summary, irq;
  logic [7:0] got;
  int fail_count = 0;
  int compares = 0;
  int rejects = 0;
  int rej_base = 0;
  // Kind, control value, flags expected; host mode decides what bit 1 means
  row_s rows [0:11] = '{'{4'h0, 8'h00, 8'h80}, '{4'h1, 8'h00, 8'h20}, '{4'h2, 8'h00, 8'h20},
    '{4'h3, 8'h00, 8'h10}, '{4'h9, 8'h00, 8'h00}, '{4'h4, 8'h00, 8'h08}, '{4'h5, 8'h00, 8'h04},
    '{4'h6, 8'h00, 8'h02}, '{4'h6, 8'h08, 8'h00}, '{4'h7, 8'h08, 8'h02}, '{4'h7, 8'h00, 8'h00},
    '{4'h8, 8'h00, 8'h01}};

  always #12.5 clock = ~clock;

  // Reject is a strobe, so count its cycles rather than look at it once
  always @(posedge clock) begin
    if (packet_reject === 1'b1) begin
      rejects <= rejects + 1;
    end
  end

  usb_error_flag_unit #(.TURNAROUND_BITS(4)) dut (.clock(clock), .rst(rst), .clock_enable(clock_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .bit_stuff_fault(bsf), .dma_grant_late(dgl), .buffer_overrun(bov),
    .eop_seen(eop), .bit_tick(btk), .bus_active(bac), .partial_byte_fault(pbf), .data_check_fault(dcf),
    .token_check_fault(tcf), .frame_countdown_zero(fcz), .transfer_active(tra),
    .packet_id_check_fault(pid), .rx_byte_valid(rbv), .packet_reject(packet_reject),
    .truncate_packet(truncate_packet), .host_mode(host_mode), .error_summary(error_summary), .irq(irq));

  usb_fault_peer peer (.clock(clock), .rst(rst), .fire(fire), .kind(kind), .bit_stuff_fault(bsf),
    .dma_grant_late(dgl), .buffer_overrun(bov), .eop_seen(eop), .bit_tick(btk), .bus_active(bac),
    .partial_byte_fault(pbf), .data_check_fault(dcf), .token_check_fault(tcf),
    .frame_countdown_zero(fcz), .transfer_active(tra), .packet_id_check_fault(pid), .rx_byte_valid(rbv));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic go(input logic [3:0] k);
    @(posedge clock);
    fire <= 1'b1;
    kind <= k;
    @(posedge clock);
    fire <= 1'b0;
    repeat (40) @(posedge clock);
  endtask

  task automatic stop_test;
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    fail_count++;
    stop_test;
  end

  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    wr(4'h1, 8'hFF);
    foreach (rows[i]) begin
      wr(4'h2, rows[i].ctrl);
      rej_base = rejects;
      go(rows[i].kind);
      chk({7'h00, rejects != rej_base}, {7'h00, rows[i].kind == 4'h0 || rows[i].kind == 4'h5});
      rd(4'h0, got);
      chk(got, rows[i].flags);
      rd(4'h3, got);
      chk(got, (rows[i].flags != 8'h00) ? 8'h02 : 8'h00);
      chk({7'h00, irq}, {7'h00, rows[i].flags != 8'h00});
      chk({7'h00, error_summary}, {7'h00, rows[i].flags != 8'h00});
      wr(4'h0, rows[i].flags);
      rd(4'h0, got);
      chk(got, 8'h00);
    end
    // Overrun holds truncation until the end of packet
    go(4'h2);
    chk({7'h00, truncate_packet}, 8'h01);
    go(4'h3);
    chk({7'h00, truncate_packet}, 8'h00);
    wr(4'h0, 8'hFF);
    // Reserved bit ignores writes and masking gates the summary
    wr(4'h1, 8'h00);
    rd(4'h1, got);
    chk(got, 8'h00);
    wr(4'h1, 8'h40);
    rd(4'h1, got);
    chk(got, 8'h00);
    go(4'h8);
    wr(4'h0, 8'h00);
    rd(4'h0, got);
    chk(got, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(4'h1, 8'h01);
    rd(4'h3, got);
    chk(got, 8'h02);
    wr(4'h2, 8'h08);
    @(posedge clock);
    #1;
    chk({7'h00, host_mode}, 8'h01);
    rd(4'hF, got);
    chk(got, 8'h00);
    // Second reset clears both registers
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(4'h0, got);
    chk(got, 8'h00);
    rd(4'h1, got);
    chk(got, 8'h00);
    // Event and write-one clear in the same cycle: the event wins
    @(posedge clock);
    fire <= 1'b1;
    kind <= 4'h8;
    @(posedge clock);
    fire <= 1'b0;
    reg_write <= 1'b1;
    reg_addr <= 4'h0;
    reg_wdata <= 8'h01;
    @(posedge clock);
    reg_write <= 1'b0;
    rd(4'h0, got);
    chk(got, 8'h01);
    // Clock enable low freezes the registers against a write
    @(posedge clock);
    clock_enable <= 1'b0;
    wr(4'h1, 8'h0F);
    @(posedge clock);
    clock_enable <= 1'b1;
    rd(4'h1, got);
    chk(got, 8'h00);
    stop_test;
  end
endmodule

// [verification/usb_fault_peer.sv]
`timescale 1ns/10ps
module usb_fault_peer (
  input wire logic clock,
  input wire logic rst,
  input wire logic fire,
  input wire logic [3:0] kind,
  output logic bit_stuff_fault,
  output logic dma_grant_late,
  output logic buffer_overrun,
  output logic eop_seen,
  output logic bit_tick,
  output logic bus_active,
  output logic partial_byte_fault,
  output logic data_check_fault,
  output logic token_check_fault,
  output logic frame_countdown_zero,
  output logic transfer_active,
  output logic packet_id_check_fault,
  output logic rx_byte_valid
);
  logic fire_r;
  logic [3:0] kind_r;
  logic [2:0] stuff_r;
  logic [4:0] busy_r;
  logic tick_r;
  // Peer reacts one cycle after the bench asks, so events arrive off any bus edge
  always_ff @(posedge clock) begin
    fire_r <= rst ? 1'b0 : fire;
    kind_r <= kind;
  end
  // Stuff faults come from the line domain, so stretch them past the synchroniser
  always_ff @(posedge clock) begin
    if (rst || (fire && kind == 4'h0)) begin
      stuff_r <= rst ? 3'h0 : 3'h4;
    end else if (stuff_r != 3'h0) begin
      stuff_r <= stuff_r - 3'h1;
    end
  end
  // Bit times every other clock, free running like the line receiver
  always_ff @(posedge clock) begin
    tick_r <= rst ? 1'b0 : ~tick_r;
  end
  // Kind 9 leaves idle in the same cycle as the end of packet, kind 3 stays idle
  always_ff @(posedge clock) begin
    if (rst || (fire && kind == 4'h9)) begin
      busy_r <= rst ? 5'h00 : 5'h1F;
    end else if (busy_r != 5'h00) begin
      busy_r <= busy_r - 5'h01;
    end
  end
  assign bit_stuff_fault = stuff_r != 3'h0;
  assign dma_grant_late = fire_r && kind_r == 4'h1;
  assign buffer_overrun = fire_r && kind_r == 4'h2;
  assign eop_seen = fire_r && (kind_r == 4'h3 || kind_r == 4'h9);
  assign bit_tick = tick_r;
  assign bus_active = busy_r != 5'h00;
  assign rx_byte_valid = bus_active;
  assign partial_byte_fault = fire_r && kind_r == 4'h4;
  assign data_check_fault = fire_r && kind_r == 4'h5;
  assign token_check_fault = fire_r && kind_r == 4'h6;
  assign frame_countdown_zero = fire_r && kind_r == 4'h7;
  assign transfer_active = fire_r && kind_r == 4'h7;
  assign packet_id_check_fault = fire_r && kind_r == 4'h8;
endmodule
